// >>> rtl/mst_pkg.sv
package mst_pkg;

   // ---------------------------------------------------------------
   // Bus cycle kinds
   // ---------------------------------------------------------------
   localparam logic [2:0] CYC_IDLE = 3'h0;   // No transaction
   localparam logic [2:0] CYC_MRD = 3'h1;    // Memory read
   localparam logic [2:0] CYC_MWR = 3'h2;    // Memory write
   localparam logic [2:0] CYC_REF = 3'h3;    // Refresh
   localparam logic [2:0] CYC_IO = 3'h4;     // I/O transaction
   localparam logic [2:0] CYC_IACK = 3'h5;   // Interrupt acknowledge

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic RST_FORCE_BYTE = 1'b1;   // Byte width forced low
   localparam logic RST_HIGH_SEL_EN = 1'b0;  // High select is port bit
   localparam logic RST_PORT_BIT = 1'b1;     // Port bit idles high

   // ---------------------------------------------------------------
   // Bus states, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001,
      ST_T1 = 5'b0_0010,
      ST_T2 = 5'b0_0100,
      ST_T3 = 5'b0_1000,
      ST_T4 = 5'b1_0000
   } mst_state_t;

endpackage

// >>> rtl/mst_strobe.sv
// Behaviour
// - After reset: low select, width low, top bit
// - After reset, high select pin is port bit
// - 16-bit mode: selects gated by byte strobes
// - Selects follow address timing, no delay
// - Mux ref low end T2 to end T4
// - Column ref low end T3 to end T4
// - Row ref low end T1 to end T4
// - Wait low stretches T3 on bus/io tick
// - Byte-wide 16-bit access adds second transaction
module mst_strobe
   import mst_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   // Bus timing enables
   input wire logic bus_tick_in,      // bus_cycle_clock edge pulse
   input wire logic io_tick_in,       // io_cycle_clock edge pulse
   // Transaction request
   input wire logic start_in,         // Begin a transaction
   input wire logic [2:0] cycle_kind_in,
   input wire logic top_address_bit_in,
   input wire logic word_access_in,   // 16-bit memory access
   input wire logic lower_byte_strobe_in,
   input wire logic upper_byte_strobe_in,
   // Configuration
   input wire logic cfg_wr_in,        // Load mode bits
   input wire logic cfg_force_byte_in,
   input wire logic cfg_high_sel_en_in,
   input wire logic port_bit_in,      // Alternate port value
   // Wait from the outside party, active low
   input wire logic wait_n_in,
   // Width pin from outside decoders, open-drain level
   input wire logic byte_width_indicator_in,
   // Strobe outputs, active low
   output logic ram_select_low_byte_n_out,
   output logic ram_select_high_byte_n_out,
   output logic byte_width_indicator_out,
   output logic byte_width_indicator_oe_n_out,
   output logic mux_timing_ref_n_out,
   output logic column_timing_ref_n_out,
   output logic row_timing_ref_n_out,
   // Status
   output logic busy_out,
   output logic second_xfer_out       // High during the extra byte cycle
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   mst_state_t state, next_state;
   logic force_byte, next_force_byte;     // Width forced low
   logic high_sel_en, next_high_sel_en;   // High select is chip select
   logic [2:0] kind, next_kind;           // Latched cycle kind
   logic a_top, next_a_top;               // Latched top address
   logic word, next_word;                 // Latched word access
   logic second, next_second;             // Extra byte transaction
   logic bw_low, next_bw_low;             // Byte-wide seen this cycle
   logic sel_l, next_sel_l;
   logic sel_h, next_sel_h;
   logic bw_oe_n, next_bw_oe_n;
   logic ref_a, next_ref_a;
   logic ref_c, next_ref_c;
   logic ref_r, next_ref_r;
   logic busy, next_busy;                 // Registered so the pin is a flop
   logic tick;

   // Memory or refresh cycle: only these move the timing refs
   function automatic logic is_mem(input logic [2:0] k);
      return (k == CYC_MRD) || (k == CYC_MWR) || (k == CYC_REF);
   endfunction

   // I/O and acknowledge cycles run on the slower I/O clock
   function automatic logic is_io(input logic [2:0] k);
      return (k == CYC_IO) || (k == CYC_IACK);
   endfunction

   assign tick = is_io(kind) ? io_tick_in : bus_tick_in;

   // ---------------------------------------------------------------
   // Next-value logic
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_force_byte = force_byte;
      next_high_sel_en = high_sel_en;
      next_kind = kind;
      next_a_top = a_top;
      next_word = word;
      next_second = second;
      next_bw_low = bw_low;
      next_sel_l = sel_l;
      next_sel_h = sel_h;
      next_bw_oe_n = bw_oe_n;
      next_ref_a = ref_a;
      next_ref_c = ref_c;
      next_ref_r = ref_r;
      // Mode changes only between transactions, so a cycle never
      // sees its lane gating switch halfway
      if (cfg_wr_in && (state == ST_IDLE)) begin
         next_force_byte = cfg_force_byte_in;
         next_high_sel_en = cfg_high_sel_en_in;
      end
      unique case (state)
         ST_IDLE: begin
            if (start_in) begin
               next_kind = cycle_kind_in;
               next_a_top = top_address_bit_in;
               next_word = word_access_in;
               next_second = 1'b0;
               next_bw_low = 1'b0;
               next_state = ST_T1;
            end
         end
         ST_T1: begin
            // Selects launch with the address at the start of T1
            if (tick) begin
               next_ref_r = ~is_mem(kind);
               next_state = ST_T2;
            end
         end
         ST_T2: begin
            if (tick) begin
               next_ref_a = ~is_mem(kind);
               next_state = ST_T3;
            end
         end
         ST_T3: begin
            // Wait sampled on the relevant tick stretches T3
            if (tick && wait_n_in) begin
               next_ref_c = ~is_mem(kind);
               next_bw_low = ~byte_width_indicator_in | force_byte;
               next_state = ST_T4;
            end
         end
         ST_T4: begin
            if (tick) begin
               next_ref_a = 1'b1;
               next_ref_c = 1'b1;
               next_ref_r = 1'b1;
               // Byte-wide target on a word access: one more cycle
               if (word && bw_low && !second &&
                   (kind == CYC_MRD || kind == CYC_MWR)) begin
                  next_second = 1'b1;
                  next_state = ST_T1;
               end else begin
                  next_second = 1'b0;
                  next_state = ST_IDLE;
               end
            end
         end
      endcase
      // Busy tracks the state that the next edge loads
      next_busy = (next_state != ST_IDLE);
      // Chip selects, same edge as the address outputs; the mode used
      // is the one this edge loads, so a start that meets a mode write
      // already runs with the new lane gating from its first cycle
      next_sel_l = 1'b1;
      next_sel_h = next_high_sel_en ? 1'b1 : port_bit_in;
      next_bw_oe_n = 1'b1;
      if (next_state != ST_IDLE && is_mem(next_kind)
          && next_kind != CYC_REF && next_a_top) begin
         if (next_force_byte) begin
            next_sel_l = 1'b0;
            next_bw_oe_n = 1'b0;
         end else begin
            next_sel_l = ~lower_byte_strobe_in;
            if (next_high_sel_en) begin
               next_sel_h = ~upper_byte_strobe_in;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         state <= ST_IDLE;
         force_byte <= RST_FORCE_BYTE;
         high_sel_en <= RST_HIGH_SEL_EN;
         kind <= CYC_IDLE;
         a_top <= 1'b0;
         word <= 1'b0;
         second <= 1'b0;
         bw_low <= 1'b0;
         sel_l <= 1'b1;
         sel_h <= RST_PORT_BIT;
         bw_oe_n <= 1'b1;
         ref_a <= 1'b1;
         ref_c <= 1'b1;
         ref_r <= 1'b1;
         busy <= 1'b0;
      end else begin
         state <= next_state;
         force_byte <= next_force_byte;
         high_sel_en <= next_high_sel_en;
         kind <= next_kind;
         a_top <= next_a_top;
         word <= next_word;
         second <= next_second;
         bw_low <= next_bw_low;
         sel_l <= next_sel_l;
         sel_h <= next_sel_h;
         bw_oe_n <= next_bw_oe_n;
         ref_a <= next_ref_a;
         ref_c <= next_ref_c;
         ref_r <= next_ref_r;
         busy <= next_busy;
      end
   end

   // Open-drain width pin: output level is always low
   assign ram_select_low_byte_n_out = sel_l;
   assign ram_select_high_byte_n_out = sel_h;
   assign byte_width_indicator_out = 1'b0;
   assign byte_width_indicator_oe_n_out = bw_oe_n;
   assign mux_timing_ref_n_out = ref_a;
   assign column_timing_ref_n_out = ref_c;
   assign row_timing_ref_n_out = ref_r;
   assign busy_out = busy;
   assign second_xfer_out = second;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_row_after_t1;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (state == ST_T1 && tick && is_mem(kind)) |=> !row_timing_ref_n_out;
   endproperty
   a_row_after_t1: assert property (p_row_after_t1)
      else $error("row ref not low after T1");

   property p_mux_after_t2;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (state == ST_T2 && tick && is_mem(kind)) |=> !mux_timing_ref_n_out;
   endproperty
   a_mux_after_t2: assert property (p_mux_after_t2)
      else $error("mux ref not low after T2");

   property p_col_after_t3;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (state == ST_T3 && tick && wait_n_in && is_mem(kind))
         |=> !column_timing_ref_n_out;
   endproperty
   a_col_after_t3: assert property (p_col_after_t3)
      else $error("column ref not low after T3");

   property p_refs_rise_t4;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (state == ST_T4 && tick) |=> (mux_timing_ref_n_out &&
         column_timing_ref_n_out && row_timing_ref_n_out);
   endproperty
   a_refs_rise_t4: assert property (p_refs_rise_t4)
      else $error("refs not high after T4");

   property p_refs_idle_io;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (is_io(kind) || state == ST_IDLE) |-> row_timing_ref_n_out;
   endproperty
   a_refs_idle_io: assert property (p_refs_idle_io)
      else $error("row ref low outside memory cycle");

   property p_wait_holds;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (state == ST_T3 && !wait_n_in) |=> (state == ST_T3);
   endproperty
   a_wait_holds: assert property (p_wait_holds)
      else $error("wait did not stretch T3");

   property p_forced_low;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (!ram_select_low_byte_n_out && force_byte)
         |-> !byte_width_indicator_oe_n_out;
   endproperty
   a_forced_low: assert property (p_forced_low)
      else $error("width not driven low with low select");

   property p_high_port;
      @(posedge clk_sys_in) disable iff (!nrst_in)
      (!high_sel_en && !$past(high_sel_en))
         |-> (ram_select_high_byte_n_out == $past(port_bit_in));
   endproperty
   a_high_port: assert property (p_high_port)
      else $error("high select pin not following port bit");

endmodule

// >>> verif/memory_select_and_strobe_timing_bench.sv
module memory_select_and_strobe_timing_bench;
   import mst_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic btk = 1'b0, itk = 1'b0, start = 1'b0, atop = 1'b0, word = 1'b0;
   logic lo = 1'b0, hi = 1'b0, cwr = 1'b0, cfb = 1'b1, chs = 1'b0;
   logic pbit = 1'b1, bw = 1'b0, wait_n, pin, bwo;
   logic [2:0] kind = 3'h0;
   logic [3:0] wt = 4'h0, tcnt = 4'h0;
   logic sel_l_n, sel_h_n, oe_n, mux_n, col_n, row_n, busy, second;
   logic sl1; // Low select one cycle after the start edge
   logic [7:0] cnt [7]; // row mux col sel_l sel_h oe second
   int fails = 0;
   int compares = 0;
   always #50 clk = ~clk;
   // Bus tick every second cycle, I/O tick every fourth
   always @(posedge clk) begin
      tcnt <= tcnt + 4'h1;
      btk <= tcnt[0];
      itk <= (tcnt[1:0] == 2'h3);
   end
   mst_strobe u_dut (.clk_sys_in(clk), .nrst_in(nrst), .bus_tick_in(btk),
      .io_tick_in(itk), .start_in(start), .cycle_kind_in(kind),
      .top_address_bit_in(atop), .word_access_in(word),
      .lower_byte_strobe_in(lo), .upper_byte_strobe_in(hi),
      .cfg_wr_in(cwr), .cfg_force_byte_in(cfb), .cfg_high_sel_en_in(chs),
      .port_bit_in(pbit), .wait_n_in(wait_n), .byte_width_indicator_in(pin),
      .ram_select_low_byte_n_out(sel_l_n),
      .ram_select_high_byte_n_out(sel_h_n), .byte_width_indicator_out(bwo),
      .byte_width_indicator_oe_n_out(oe_n), .mux_timing_ref_n_out(mux_n),
      .column_timing_ref_n_out(col_n), .row_timing_ref_n_out(row_n),
      .busy_out(busy), .second_xfer_out(second));
   mst_ram_model u_ram (.clk_sys_in(clk), .bus_tick_in(btk),
      .mux_n_in(mux_n), .sel_low_n_in(sel_l_n), .width_oe_n_in(oe_n),
      .wait_ticks_in(wt), .byte_wide_in(bw), .wait_n_out(wait_n),
      .width_pin_out(pin));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      if (fails == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // One transaction; counts strobes low at each tick while busy
   task automatic run(input logic [2:0] k, input logic a, input logic w);
      int i;
      logic tk;
      for (i = 0; i < 7; i++) cnt[i] = 8'h00;
      @(posedge clk);
      start <= 1'b1;
      kind <= k;
      atop <= a;
      word <= w;
      @(posedge clk);
      start <= 1'b0;
      @(negedge clk);
      sl1 = sel_l_n;
      for (i = 0; i < 300 && busy === 1'b1; i++) begin
         tk = (k >= CYC_IO) ? itk : btk;
         if (tk === 1'b1) begin
            cnt[0] += {7'h0, !row_n};
            cnt[1] += {7'h0, !mux_n};
            cnt[2] += {7'h0, !col_n};
            cnt[3] += {7'h0, !sel_l_n};
            cnt[4] += {7'h0, !sel_h_n};
            cnt[5] += {7'h0, !oe_n};
         end
         if (second === 1'b1) cnt[6] = 8'h01;
         @(negedge clk);
      end
      check("busy_end", {7'h0, busy}, 8'h00);
      check("idle_out", {4'h0, row_n, mux_n, col_n, sel_l_n}, 8'h0f);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      // Width data level is open-drain low whatever the enable does
      check("rst_out", {2'h0, bwo, sel_l_n, sel_h_n, oe_n, row_n, busy},
         8'h1e);
      @(posedge clk);
      pbit <= 1'b0;
      repeat (2) @(negedge clk);
      check("port_bit", {7'h0, sel_h_n}, 8'h00);
      @(posedge clk);
      pbit <= 1'b1;
   endtask
   task automatic t_mem;
      int i;
      logic [7:0] w;
      for (i = 0; i < 3; i++) begin
         w = 8'(i);
         @(posedge clk);
         wt <= 4'(i);
         run(CYC_MRD + 3'(i), 1'b1, 1'b0);
         check("row", cnt[0], 8'h03 + w);
         check("mux", cnt[1], 8'h02 + w);
         check("col", cnt[2], 8'h01);
         check("sel_h", cnt[4], 8'h00);
         if (i < 2) begin
            check("sel_l", cnt[3], 8'h04 + w);
            check("oe", cnt[5], 8'h04 + w);
            check("sel_first", {7'h0, sl1}, 8'h00);
         end
      end
      @(posedge clk);
      wt <= 4'h0;
      run(CYC_MRD, 1'b0, 1'b0);
      check("sel_l_a0", cnt[3], 8'h00);
   endtask
   task automatic t_io;
      run(CYC_IO, 1'b1, 1'b0);
      check("io_refs", cnt[0] | cnt[1] | cnt[2], 8'h00);
      run(CYC_IACK, 1'b1, 1'b0);
      check("iack_refs", cnt[0] | cnt[1] | cnt[2], 8'h00);
   endtask
   task automatic t_wide;
      @(posedge clk);
      cwr <= 1'b1;
      cfb <= 1'b0;
      chs <= 1'b1;
      lo <= 1'b1;
      @(posedge clk);
      cwr <= 1'b0;
      run(CYC_MRD, 1'b1, 1'b1);
      check("lo_sel_l", cnt[3], 8'h04);
      check("lo_sel_h", cnt[4], 8'h00);
      check("lo_oe", cnt[5], 8'h00);
      check("lo_second", cnt[6], 8'h00);
      @(posedge clk);
      lo <= 1'b0;
      hi <= 1'b1;
      run(CYC_MWR, 1'b1, 1'b1);
      check("hi_sel_l", cnt[3], 8'h00);
      check("hi_sel_h", cnt[4], 8'h04);
      @(posedge clk);
      lo <= 1'b1;
      bw <= 1'b1;
      run(CYC_MRD, 1'b1, 1'b1);
      check("bw_second", cnt[6], 8'h01);
      check("bw_row", cnt[0], 8'h06);
   endtask
   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      t_reset();
      t_mem();
      t_io();
      t_wide();
      finish_test();
   end
   // Whole run needs about 130 cycles; allow far more
   initial begin
      #(100 * 30000);
      fails++;
      finish_test();
   end
endmodule

// >>> verif/mst_ram_model.sv
// ---------------------------------------------------------------
// Far-side memory: wait source and open-drain width pin
// ---------------------------------------------------------------
module mst_ram_model (
   // Clock and timing
   input wire logic clk_sys_in,
   input wire logic bus_tick_in,
   // Device strobes, active low
   input wire logic mux_n_in,
   input wire logic sel_low_n_in,
   input wire logic width_oe_n_in,
   // Behaviour chosen by the bench
   input wire logic [3:0] wait_ticks_in,
   input wire logic byte_wide_in,
   // Answers to the device
   output logic wait_n_out,
   output logic width_pin_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] waited = 4'h0; // Wait ticks already spent in T3
   // Count ticks held in wait; clear once the cycle is over
   always @(posedge clk_sys_in) begin
      if (mux_n_in) begin
         waited <= 4'h0;
      end else if (bus_tick_in && !wait_n_out) begin
         waited <= waited + 4'h1;
      end
   end
   // Wait only from T3 on, so early states are never stretched
   assign wait_n_out = !(!mux_n_in && (waited < wait_ticks_in));
   // Pull-up unless the device or a byte-wide target pulls low
   assign width_pin_out =
      !(!width_oe_n_in || (byte_wide_in && !sel_low_n_in));
endmodule
